// >>> verification/sorc_card_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Slot card stand-in: recorder or cascade peer
// ----------------------------------------
module sorc_card_model (
  input wire logic mclk,
  input wire logic [2:0] cardCode,
  input wire logic roleIn,
  input wire logic soloEng,
  input wire logic [7:0] emphSet,
  input wire sorc_pkg::sorc_smp_t [7:0] slotOut,
  output sorc_pkg::sorc_smp_t [7:0] slotIn,
  output logic [7:0] slotEmph,
  output logic [2:0] cardIdPin,
  output logic roleInPin,
  output logic casSoloPin,
  output sorc_pkg::sorc_smp_t [1:0] casStIn
);
  logic tgl = 1'b0; // Floating-line pattern
  // Plain always: the declaration gives the start value
  always @(posedge mclk) begin
    tgl <= ~tgl;
  end
  // Eight return channels; with no card the lines float, so they toggle
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      slotIn[k] = (cardCode == 3'h0) ? {24{tgl}} : 24'h040000 + 24'(k);
    end
  end
  assign slotEmph = emphSet; // Emphasis flags per channel
  assign cardIdPin = cardCode; // Card code seen at power-up
  assign roleInPin = roleIn; // Own IN/OUT switch
  // Far side master engages solo; a far slave never does
  assign casSoloPin = soloEng & ~roleIn;
  // Far slave sends its raw stereo only when we are master
  assign casStIn[0] = roleIn ? 24'h050000 : 24'h000000;
  assign casStIn[1] = roleIn ? 24'h050001 : 24'h000000;
endmodule : sorc_card_model
`default_nettype wire

// >>> verification/tb_slot_output_router_cascade.sv
`timescale 1ns/1ns
`default_nettype none
module tb_slot_output_router_cascade;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sampleTick = 1'b0;
  sorc_pkg::sorc_tap_t postTap;
  sorc_pkg::sorc_tap_t rawSum;
  sorc_pkg::sorc_tap_t mixSum;
  sorc_pkg::sorc_smp_t [15:0] dirOut;
  sorc_pkg::sorc_smp_t [7:0] slotIn, slotOut, chanRet;
  sorc_pkg::sorc_smp_t [1:0] casStIn, casStOut;
  logic [7:0] slotEmph;
  logic [7:0] emphSet = 8'h00;
  logic [2:0] cardIdPin;
  logic [2:0] cardCode = 3'h1;
  logic roleIn = 1'b0;
  logic soloEng = 1'b0;
  logic roleInPin, casSoloPin, casSoloOut, chanRetOn, soloOn, soloStat;
  int fails = 0;
  int nChecks = 0;
  always #5 mclk = ~mclk;
  sorc_router u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleTick(sampleTick), .postTap(postTap), .rawSum(rawSum),
    .dirOut(dirOut), .slotIn(slotIn), .slotEmph(slotEmph), .cardIdPin(cardIdPin),
    .roleInPin(roleInPin), .casSoloPin(casSoloPin), .casStIn(casStIn), .slotOut(slotOut),
    .casStOut(casStOut), .casSoloOut(casSoloOut), .chanRet(chanRet),
    .chanRetOn(chanRetOn), .mixSum(mixSum), .soloOn(soloOn), .soloStat(soloStat));
  sorc_card_model u_card (.mclk(mclk), .cardCode(cardCode), .roleIn(roleIn),
    .soloEng(soloEng), .emphSet(emphSet), .slotOut(slotOut), .slotIn(slotIn),
    .slotEmph(slotEmph), .cardIdPin(cardIdPin), .roleInPin(roleInPin),
    .casSoloPin(casSoloPin), .casStIn(casStIn));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in this step
    @(posedge mclk);
    if (n >= 20) begin
      fails++;
      wrap_up();
    end
  endtask : apb
  // One sample boundary, then let registered outputs settle
  task automatic tick();
    sampleTick <= 1'b1;
    @(posedge mclk);
    sampleTick <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : tick
  // Card change needs a fresh power-up; identification takes 100 cycles
  task automatic reboot(input logic [2:0] c, input logic r);
    cardCode <= c;
    roleIn <= r;
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (120) @(posedge mclk);
  endtask : reboot
  function automatic sorc_pkg::sorc_smp_t expOut(input int n, input logic [2:0] c);
    case (c)
      3'h1: return postTap.aux[n % 4];
      3'h2: return dirOut[n];
      3'h3: return dirOut[n + 8];
      3'h4: return (n % 2) ? postTap.stR : postTap.stL;
      default: return postTap.bus[n % 4];
    endcase
  endfunction : expOut
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_ident();
    logic [31:0] q;
    logic e;
    for (int c = 0; c < 6; c++) begin
      reboot(3'(c), 1'b1);
      // Return enable is registered on a sample boundary
      tick();
      apb(1'b0, sorc_pkg::OFS_STAT, 32'h0, q, e);
      chk("card", {29'h0, q[2:0]}, 32'(c));
      chk("cascFlag", {31'h0, q[4]}, {31'h0, c == 5});
      chk("masterFlag", {31'h0, q[3]}, {31'h0, c == 5});
      chk("retOn", {31'h0, chanRetOn}, {31'h0, c != 5});
    end
  endtask : s_ident
  // Each source code 0-4 on every output, then a mixed pattern
  task automatic s_route();
    logic [31:0] q, d;
    logic e;
    logic [2:0] code;
    sorc_pkg::sorc_smp_t prev;
    sorc_pkg::sorc_smp_t y;
    reboot(3'h1, 1'b0);
    prev = 24'h000000;
    apb(1'b1, 8'h0C, 32'h1, q, e);
    chk("unmappedErr", {31'h0, e}, 32'h1);
    apb(1'b1, sorc_pkg::OFS_CASC, 32'h3, q, e);
    chk("slaveCascErr", {31'h0, e}, 32'h1);
    for (int p = 0; p < 6; p++) begin
      d = 32'h0;
      for (int n = 0; n < 8; n++) begin
        d[3*n +: 3] = (p < 5) ? 3'(p) : 3'(n % 5);
      end
      apb(1'b1, sorc_pkg::OFS_SEL, d, q, e);
      apb(1'b0, sorc_pkg::OFS_SEL, 32'h0, q, e);
      chk("selBack", q, d);
      chk("holdTillTick", slotOut[0], prev);
      tick();
      tick();
      for (int n = 0; n < 8; n++) begin
        code = d[3*n +: 3];
        chk("slotOut", slotOut[n], expOut(n, code));
      end
      prev = expOut(0, d[2:0]);
    end
    // Emphasis on the last return channel only; a fresh start clears the
    // filter state, so the steady return input shows the filter working
    reboot(3'h1, 1'b0);
    emphSet <= 8'h80;
    tick();
    tick();
    apb(1'b0, sorc_pkg::OFS_STAT, 32'h0, q, e);
    chk("emphFlags", {24'h0, q[15:8]}, 32'h80);
    for (int k = 0; k < 7; k++) begin
      chk("chanRet", chanRet[k], slotIn[k]);
    end
    chk("deEmph", {31'h0, chanRet[7] === slotIn[7]}, 32'h0);
    // Two filter steps from a zero state
    y = slotIn[7] >>> sorc_pkg::DE_SHIFT;
    y = y + ((slotIn[7] - y) >>> sorc_pkg::DE_SHIFT);
    chk("deEmphVal", chanRet[7], y);
    emphSet <= 8'h00;
  endtask : s_route
  // Cascade card fitted, as master (r=1) or slave (r=0)
  task automatic s_casc(input logic r);
    logic [31:0] q;
    logic e;
    reboot(3'h5, r);
    soloEng <= 1'b1;
    apb(1'b1, sorc_pkg::OFS_SEL, 32'h924924, q, e);
    apb(1'b1, sorc_pkg::OFS_CASC, 32'h3, q, e);
    chk("cascErr", {31'h0, e}, {31'h0, ~r});
    repeat (6) tick();
    chk("retOff", chanRet[0], 32'h0);
    chk("soloOn", {31'h0, soloOn}, 32'h1);
    if (r) begin
      chk("busSum", mixSum.bus[0], rawSum.bus[0] + slotIn[0]);
      chk("auxSum", mixSum.aux[1], rawSum.aux[1] + slotIn[5]);
      chk("stSum", mixSum.stL, rawSum.stL + casStIn[0]);
      chk("soloOut", {31'h0, casSoloOut}, 32'h1);
      chk("soloStat", {31'h0, soloStat}, 32'h1);
      apb(1'b0, sorc_pkg::OFS_CASC, 32'h0, q, e);
      chk("cascBack", {30'h0, q[1:0]}, 32'h3);
    end else begin
      for (int n = 0; n < 8; n++) begin
        chk("cascOut", slotOut[n], n < 4 ? rawSum.bus[n] : rawSum.aux[n-4]);
      end
      chk("stOut", casStOut[1], rawSum.stR);
      chk("soloOut", {31'h0, casSoloOut}, 32'h0);
      chk("soloStatSlave", {31'h0, soloStat}, 32'h0);
    end
    soloEng <= 1'b0;
  endtask : s_casc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 16; k++) begin
      dirOut[k] = 24'h030000 + 24'(k);
    end
    for (int k = 0; k < 4; k++) begin
      postTap.bus[k] = 24'h010000 + 24'(k);
      postTap.aux[k] = 24'h011000 + 24'(k);
      rawSum.bus[k] = 24'h020000 + 24'(k);
      rawSum.aux[k] = 24'h021000 + 24'(k);
    end
    postTap.stL = 24'h012000;
    postTap.stR = 24'h012001;
    rawSum.stL = 24'h022000;
    rawSum.stR = 24'h022001;
    s_ident();
    s_route();
    s_casc(1'b1);
    s_casc(1'b0);
    wrap_up();
  end
endmodule : tb_slot_output_router_cascade
`default_nettype wire

// >>> verilog/sorc_pkg.sv
// Behaviour
// - Detect input emphasis, de-emphasize it automatically
// - Outputs never carry emphasis
// - Eight slot inputs and eight slot outputs
// - Each output picks bus, aux, direct 1-16
// - Slot inputs feed channels 17-24 fixed
// - Bus, aux, stereo taps are post-fader
// - Outputs 1-4 pick bus/aux n, direct n/n+8
// - Outputs 5-8 pick bus/aux n-4, direct n/n+8
// - Identify card type once after power-up
// - Cascade card disables channels 17-24
// - Role switch: OUT is slave, IN master
// - Cascade overrides the output selections
// - Buses summed; master faders set level
// - Aux buses joined; master sends set level
// - Effects buses stay local per console
// - Stereo joined; master stereo fader sets level
// - Solo linked, engaged only from master
// - Cascade config only on master console
`default_nettype none
package sorc_pkg;
  // ----------------------------------------
  // Audio carriers
  // ----------------------------------------
  typedef logic signed [23:0] sorc_smp_t;
  typedef struct packed {
    sorc_smp_t [3:0] bus;
    sorc_smp_t [3:0] aux;
    sorc_smp_t stL;
    sorc_smp_t stR;
  } sorc_tap_t;
  // Output source codes
  typedef enum logic [2:0] {
    SRC_BUS, SRC_AUX, SRC_DIR_LO, SRC_DIR_HI, SRC_STEREO
  } sorc_src_t;
  // Card codes, also the pin encoding
  typedef enum logic [2:0] {
    CARD_NONE, CARD_OPT, CARD_TDM, CARD_AES, CARD_MCH, CARD_CASC
  } sorc_card_t;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CASC = 8'h08;
  localparam int SEL_W = 3;
  localparam logic [23:0] SEL_RST = 24'h000000;
  localparam int ST_CARD = 0;
  localparam int ST_MASTER = 3;
  localparam int ST_CASC = 4;
  localparam int ST_EMPH = 8;
  localparam int CF_SOLO = 0;
  localparam int CF_STAT = 1;
  localparam logic [1:0] CF_RST = 2'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ID_SETTLE_US = 1;
  localparam int ID_SETTLE_CYC = ID_SETTLE_US * CLK_MHZ;
  localparam int DE_SHIFT = 2;
endpackage : sorc_pkg
`default_nettype wire

// >>> verilog/sorc_router.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module sorc_router (
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample boundary pulse
  input wire logic sampleTick,
  // Post-fader taps, pre conversion
  input wire sorc_pkg::sorc_tap_t postTap,
  // Raw bus sums, before master faders
  input wire sorc_pkg::sorc_tap_t rawSum,
  input wire sorc_pkg::sorc_smp_t [15:0] dirOut,
  // Slot card side
  input wire sorc_pkg::sorc_smp_t [7:0] slotIn,
  input wire logic [7:0] slotEmph,
  input wire logic [2:0] cardIdPin,
  input wire logic roleInPin,
  input wire logic casSoloPin,
  input wire sorc_pkg::sorc_smp_t [1:0] casStIn,
  output sorc_pkg::sorc_smp_t [7:0] slotOut,
  output sorc_pkg::sorc_smp_t [1:0] casStOut,
  output logic casSoloOut,
  // Mixer side
  output sorc_pkg::sorc_smp_t [7:0] chanRet,
  output logic chanRetOn,
  output sorc_pkg::sorc_tap_t mixSum,
  output logic soloOn,
  output logic soloStat
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Saturating add; avoids wrap on summed buses
  function automatic sorc_pkg::sorc_smp_t satAdd(
    input sorc_pkg::sorc_smp_t a,
    input sorc_pkg::sorc_smp_t b
  );
    logic signed [24:0] s;
    s = 25'(a) + 25'(b);
    if (s > 25'sh07FFFFF) begin
      satAdd = 24'sh7FFFFF;
    end else if (s < -25'sh0800000) begin
      satAdd = -24'sh800000;
    end else begin
      satAdd = s[23:0];
    end
  endfunction : satAdd

  // One-pole shelf; approximates the de-emphasis curve
  function automatic sorc_pkg::sorc_smp_t deEmph(
    input sorc_pkg::sorc_smp_t x,
    input sorc_pkg::sorc_smp_t yp
  );
    logic signed [24:0] d;
    d = 25'(x) - 25'(yp);
    deEmph = satAdd(yp, 24'(d >>> sorc_pkg::DE_SHIFT));
  endfunction : deEmph

  // ----------------------------------------
  // Pin synchronisers (3 stages)
  // ----------------------------------------
  logic [4:0] pinS1_r; // First stage only feeds pinS2_r
  logic [4:0] pinS2_r;
  logic [4:0] pinS3_r;
  logic [4:0] pinStab_r; // Agreed value
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinS1_r <= 5'h00;
      pinS2_r <= 5'h00;
      pinS3_r <= 5'h00;
      pinStab_r <= 5'h00;
    end else begin
      pinS1_r <= {casSoloPin, roleInPin, cardIdPin};
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      // Take bits only where stages 2 and 3 agree
      pinStab_r <= (pinS2_r & pinS3_r)
                 | (pinStab_r & (pinS2_r | pinS3_r));
    end
  end

  // ----------------------------------------
  // Card identification after reset
  // ----------------------------------------
  logic [7:0] idCnt_r; // Settle timer
  logic idDone_r;
  sorc_pkg::sorc_card_t card_r;
  logic master_r; // Cascade role IN
  logic casc_r; // Cascade card fitted
  // Sampled once; the card cannot change while powered
  always_ff @(posedge mclk) begin
    if (rst) begin
      idCnt_r <= 8'h00;
      idDone_r <= 1'b0;
      card_r <= sorc_pkg::CARD_NONE;
      master_r <= 1'b0;
      casc_r <= 1'b0;
    end else if (!idDone_r) begin
      if (32'(idCnt_r) < sorc_pkg::ID_SETTLE_CYC - 1) begin
        idCnt_r <= idCnt_r + 8'h01;
      end else begin
        idDone_r <= 1'b1;
        if (pinStab_r[2:0] > 3'h5) begin
          card_r <= sorc_pkg::CARD_NONE; // Unknown code
        end else begin
          card_r <= sorc_pkg::sorc_card_t'(pinStab_r[2:0]);
        end
        casc_r <= (pinStab_r[2:0] == 3'h5);
        // IN means master, OUT means slave
        master_r <= (pinStab_r[2:0] == 3'h5) & pinStab_r[3];
      end
    end
  end

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  logic [23:0] sel_r; // Pending selections
  logic [1:0] cfg_r; // Master cascade config
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic setup;
  logic wrOk;
  logic [7:0] emph_r;
  assign setup = psel & ~penable;
  assign wrOk = psel & penable & pready_r & pwrite & ~pslverr_r;

  // Decode in setup so the access cycle answers at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      if (setup) begin
        case (paddr)
          sorc_pkg::OFS_SEL: begin
            prdata_r <= {8'h00, sel_r};
          end
          sorc_pkg::OFS_STAT: begin
            prdata_r[sorc_pkg::ST_CARD +: 3] <= card_r;
            prdata_r[sorc_pkg::ST_MASTER] <= master_r;
            prdata_r[sorc_pkg::ST_CASC] <= casc_r;
            prdata_r[sorc_pkg::ST_EMPH +: 8] <= emph_r;
          end
          sorc_pkg::OFS_CASC: begin
            // Slave has no cascade page
            if (master_r) begin
              prdata_r[1:0] <= cfg_r;
            end else begin
              pslverr_r <= 1'b1;
            end
          end
          default: begin
            pslverr_r <= 1'b1; // Unmapped
          end
        endcase
      end
    end
  end

  // Selection store; held until rewritten
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_r <= sorc_pkg::SEL_RST;
    end else if (wrOk && paddr == sorc_pkg::OFS_SEL) begin
      sel_r <= pwdata[23:0];
    end
  end

  // Cascade config, writable on master only
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= sorc_pkg::CF_RST;
    end else if (!master_r) begin
      cfg_r <= sorc_pkg::CF_RST;
    end else if (wrOk && paddr == sorc_pkg::OFS_CASC) begin
      cfg_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // De-emphasis of slot inputs
  // ----------------------------------------
  sorc_pkg::sorc_smp_t [7:0] dePrev_r; // Filter state
  sorc_pkg::sorc_smp_t [7:0] slotDe; // Flat audio
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Flagged channels go through the filter
      slotDe[i] = slotEmph[i] ? deEmph(slotIn[i], dePrev_r[i])
                              : slotIn[i];
    end
  end

  // Filter state advances once per sample
  always_ff @(posedge mclk) begin
    if (rst) begin
      dePrev_r <= '0;
      emph_r <= 8'h00;
    end else if (sampleTick) begin
      dePrev_r <= slotDe;
      emph_r <= slotEmph;
    end
  end

  // ----------------------------------------
  // Returns to channels 17-24
  // ----------------------------------------
  sorc_pkg::sorc_smp_t [7:0] chanRet_r;
  logic chanRetOn_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      chanRet_r <= '0;
      chanRetOn_r <= 1'b0;
    end else if (sampleTick) begin
      // Fixed one-to-one map
      chanRetOn_r <= idDone_r & ~casc_r;
      for (int i = 0; i < 8; i++) begin
        chanRet_r[i] <= casc_r ? '0 : slotDe[i];
      end
    end
  end

  // ----------------------------------------
  // Slot output selection
  // ----------------------------------------
  logic [23:0] selAct_r; // Applied selections
  always_ff @(posedge mclk) begin
    if (rst) begin
      selAct_r <= sorc_pkg::SEL_RST;
    end else if (sampleTick) begin
      selAct_r <= sel_r; // Sample-aligned swap
    end
  end

  sorc_pkg::sorc_smp_t [7:0] pick;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      // Post-fader taps only
      case (sorc_pkg::sorc_src_t'(selAct_r[n*3 +: 3]))
        sorc_pkg::SRC_BUS: begin
          pick[n] = postTap.bus[n % 4];
        end
        sorc_pkg::SRC_AUX: begin
          pick[n] = postTap.aux[n % 4];
        end
        sorc_pkg::SRC_DIR_LO: begin
          pick[n] = dirOut[n]; // Channels 1-8
        end
        sorc_pkg::SRC_DIR_HI: begin
          pick[n] = dirOut[n + 8]; // Channels 9-16
        end
        sorc_pkg::SRC_STEREO: begin
          pick[n] = (n % 2 == 0) ? postTap.stL : postTap.stR;
        end
        default: begin
          pick[n] = postTap.bus[n % 4]; // Spare codes as bus
        end
      endcase
    end
  end

  // ----------------------------------------
  // Cascade link and slot outputs
  // ----------------------------------------
  sorc_pkg::sorc_smp_t [7:0] slotOut_r;
  sorc_pkg::sorc_smp_t [1:0] casStOut_r;
  // Eight channels out; only flat audio leaves
  always_ff @(posedge mclk) begin
    if (rst) begin
      slotOut_r <= '0;
      casStOut_r <= '0;
    end else if (sampleTick) begin
      if (!casc_r) begin
        slotOut_r <= pick;
        casStOut_r <= '0;
      end else if (!master_r) begin
        // Slave sends raw sums, ignoring selections
        slotOut_r <= {rawSum.aux, rawSum.bus};
        casStOut_r <= {rawSum.stR, rawSum.stL};
      end else begin
        slotOut_r <= '0; // Master only receives
        casStOut_r <= '0;
      end
    end
  end

  // Master adds the slave's sums before its faders
  sorc_pkg::sorc_tap_t mixSum_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mixSum_r <= '0;
    end else if (sampleTick) begin
      mixSum_r <= rawSum; // Effects never crossed
      if (casc_r && master_r) begin
        for (int k = 0; k < 4; k++) begin
          mixSum_r.bus[k] <= satAdd(rawSum.bus[k], slotIn[k]);
          mixSum_r.aux[k] <= satAdd(rawSum.aux[k], slotIn[k + 4]);
        end
        mixSum_r.stL <= satAdd(rawSum.stL, casStIn[0]);
        mixSum_r.stR <= satAdd(rawSum.stR, casStIn[1]);
      end
    end
  end

  // ----------------------------------------
  // Solo link
  // ----------------------------------------
  logic soloOn_r;
  logic soloStat_r;
  logic casSoloOut_r;
  // Only the master engages solo
  always_ff @(posedge mclk) begin
    if (rst) begin
      soloOn_r <= 1'b0;
      soloStat_r <= 1'b0;
      casSoloOut_r <= 1'b0;
    end else if (casc_r && master_r) begin
      soloOn_r <= cfg_r[sorc_pkg::CF_SOLO];
      soloStat_r <= cfg_r[sorc_pkg::CF_STAT];
      casSoloOut_r <= cfg_r[sorc_pkg::CF_SOLO];
    end else if (casc_r) begin
      soloOn_r <= pinStab_r[4]; // Follows the master
      soloStat_r <= 1'b0;
      casSoloOut_r <= 1'b0;
    end else begin
      soloOn_r <= 1'b0;
      soloStat_r <= 1'b0;
      casSoloOut_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign slotOut = slotOut_r;
  assign casStOut = casStOut_r;
  assign casSoloOut = casSoloOut_r;
  assign chanRet = chanRet_r;
  assign chanRetOn = chanRetOn_r;
  assign mixSum = mixSum_r;
  assign soloOn = soloOn_r;
  assign soloStat = soloStat_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CASC_NO_RET:
    assert property (casc_r && sampleTick |=> chanRet_r == '0 && !chanRetOn_r)
    else $error("channel returns live with cascade card");
  AST_RET_MAP:
    assert property (idDone_r && !casc_r && sampleTick
                     |=> chanRet_r[3] == $past(slotDe[3]))
    else $error("slot input 4 not on channel 20");
  AST_DE_FLAT:
    assert property (sampleTick && !slotEmph[0] |=> dePrev_r[0] == $past(slotIn[0]))
    else $error("flat input altered");
  AST_SEL_HOLD:
    assert property (!sampleTick |=> selAct_r == $past(selAct_r))
    else $error("selection changed off a sample boundary");
  AST_OUT_DIRHI:
    assert property (!casc_r && sampleTick && selAct_r[20:18] == 3'h3
                     |=> slotOut_r[6] == $past(dirOut[14]))
    else $error("output 7 missed direct 15");
  AST_OUT_BUS:
    assert property (!casc_r && sampleTick && selAct_r[14:12] == 3'h0
                     |=> slotOut_r[4] == $past(postTap.bus[0]))
    else $error("output 5 missed bus 1");
  AST_SLAVE_AUTO:
    assert property (casc_r && !master_r && sampleTick
                     |=> slotOut_r[5] == $past(rawSum.aux[1]))
    else $error("slave output ignored cascade map");
  AST_SLAVE_NOCFG:
    assert property (!master_r |-> cfg_r == 2'h0 && !casSoloOut_r)
    else $error("slave holds cascade config");
  AST_ID_ONCE:
    assert property (idDone_r |=> idDone_r && $stable(card_r))
    else $error("card type changed after identification");
  AST_APB_ONE:
    assert property (setup |=> pready_r ##1 !pready_r)
    else $error("APB answer not one cycle");

  COV_CASC_MASTER: cover property (idDone_r && casc_r && master_r);
  COV_STEREO_SEL: cover property (sampleTick && selAct_r[2:0] == 3'h4);
  COV_EMPH: cover property (sampleTick && slotEmph != 8'h00);
endmodule : sorc_router
`default_nettype wire
